// ===== common/state_save_pkg.sv
package state_save_pkg;

	// Register byte offsets on the bus
	localparam logic [11:0] OFF_CTRL      = 12'h000;
	localparam logic [11:0] OFF_STATUS    = 12'h004;
	localparam logic [11:0] OFF_CONFIG    = 12'h008;
	localparam logic [11:0] OFF_ENA_LO    = 12'h00c;
	localparam logic [11:0] OFF_ENA_HI    = 12'h010;
	localparam logic [11:0] OFF_IMASK_LO  = 12'h014;
	localparam logic [11:0] OFF_IMASK_HI  = 12'h018;
	localparam logic [11:0] OFF_AREA      = 12'h01c;
	localparam logic [11:0] OFF_INUSE_LO  = 12'h020;
	localparam logic [11:0] OFF_INUSE_HI  = 12'h024;
	localparam logic [11:0] OFF_MOD_LO    = 12'h028;
	localparam logic [11:0] OFF_MOD_HI    = 12'h02c;
	localparam logic [11:0] OFF_LR_CTX    = 12'h030;
	localparam logic [11:0] OFF_LR_ADDR   = 12'h034;
	localparam logic [11:0] OFF_LR_CMP_LO = 12'h038;
	localparam logic [11:0] OFF_LR_CMP_HI = 12'h03c;
	localparam logic [11:0] OFF_VCSR      = 12'h040;
	localparam logic [11:0] OFF_VCMASK    = 12'h044;
	localparam logic [11:0] OFF_REQUESTED_COMPONENT_MASK_LO   = 12'h048;
	localparam logic [11:0] OFF_REQUESTED_COMPONENT_MASK_HI   = 12'h04c;

	// Window selects: component file at 0x100, save memory at 0x800
	localparam logic [3:0] COMP_WIN = 4'h1;

	// Control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_OP    = 1;

	// Configuration register fields
	localparam int CFG_OSE  = 0;
	localparam int CFG_TS   = 3;
	localparam int CFG_AM   = 5;
	localparam int CFG_AC   = 8;
	localparam int CFG_CPL  = 9;
	localparam int CFG_NR   = 11;
	localparam int CFG_CMPS = 12;

	// Status register fields
	localparam int ST_BUSY  = 0;
	localparam int ST_DONE  = 1;
	localparam int ST_FAULT = 2;
	localparam int ST_FORM  = 5;

	// Save-area layout in 32-bit words from the area base
	localparam logic [8:0] W_COMP0   = 9'h000;
	localparam logic [8:0] W_COMP1   = 9'h001;
	localparam logic [8:0] W_VCSR    = 9'h006;
	localparam logic [8:0] W_VCMASK  = 9'h007;
	localparam logic [8:0] W_HDR     = 9'h080;
	localparam logic [8:0] W_EXT     = 9'h090;
	localparam logic [6:0] HDR_WORDS = 7'h10;
	localparam logic [6:0] LAST_COMP = 7'h3e;
	localparam logic [5:0] ALIGN_MSK = 6'h3f;
	localparam logic [1:0] CPL_USER  = 2'h3;

	// Reset and initial values
	localparam logic [31:0] VCSR_INIT   = 32'h00001f80;
	localparam logic [31:0] VCMASK_VAL  = 32'h0000ffff;
	localparam logic [63:0] ALL_ONES    = 64'hffffffffffffffff;
	localparam logic [15:0] CFG_RST     = 16'h0000;
	localparam logic [63:0] ENA_RST     = 64'h0000000000000003;

	// Fault codes
	typedef enum logic [2:0] {
		FLT_NONE = 3'b000,
		FLT_UD   = 3'b001,
		FLT_NM   = 3'b010,
		FLT_GP   = 3'b011,
		FLT_AC   = 3'b100
	} fault_t;

	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_CHECK = 3'b001,
		S_HDR   = 3'b010,
		S_VALID = 3'b011,
		S_COMP  = 3'b100,
		S_VC    = 3'b101,
		S_WRAP  = 3'b110,
		S_FIN   = 3'b111
	} seq_t;

endpackage

// ===== src/area_offset.sv
`timescale 1ns/1ps
module area_offset (
	// Component and layout
	input  wire logic [5:0]  comp_idx,
	input  wire logic [63:0] cmp_map,
	input  wire logic        compact,
	// Word offset from area base
	output logic      [8:0]  word_off
);
	logic [8:0] rank; // Compaction bits from 2 up, below this component

	// Legacy slots, standard slot, or packed rank
	always_comb begin
		rank = '0;
		for (int k = 2; k < 63; k++) begin
			if (k < comp_idx && cmp_map[k])
				rank = rank + 9'h001;
		end
		if (comp_idx == 6'h00) begin
			word_off = state_save_pkg::W_COMP0;
		end else if (comp_idx == 6'h01) begin
			word_off = state_save_pkg::W_COMP1;
		end else if (compact) begin
			word_off = state_save_pkg::W_EXT + rank;
		end else begin
			word_off = state_save_pkg::W_EXT + {3'b000, comp_idx} - 9'h002;
		end
	end
endmodule // area_offset

// ===== src/state_save_restore.sv
`timescale 1ns/1ps
// Summary of operation
// - Requested mask is enabled AND instruction mask
// - Save-enable clear gives invalid-opcode, no update
// - Task-switched bit 3 gives device-unavailable fault
// - Unaligned area gives general-protection fault
// - User alignment-check may replace that fault
// - Save merges in-use bits into state bitmap
// - Every requested component saved, in use or not
// - Save never writes the compaction bitmap
// - Save uses legacy or standard placement
// - Save stores vector control on bit 1/2
// - Compaction bit 63 selects restore form
// - Without support, always standard form
// - Standard form header faults
// - Restore initializes or loads requested components
// - Standard form vector control load, legality fault
// - Compacted form header faults
// - Compacted clear bit 1 sets reset value
// - Compacted vector control load only bit 1
// - In-use tracking update on restore
// - Modified tracking update on restore
// - Restore writes the last-restore record
// - In-use zero guarantees initial configuration
module state_save_restore (
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	// Wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [11:0] WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// Status
	output logic             BUSY
);
	// Whole module state
	typedef struct packed {
		state_save_pkg::seq_t   st;
		logic [6:0]             idx;
		logic                   op;       // 1 = restore
		state_save_pkg::fault_t fault;
		logic                   done;
		logic                   busy;
		logic                   form;     // 1 = compacted restore
		logic [63:0]            requested_component_mask;
		logic [63:0]            bv;
		logic [63:0]            cmp;
		logic                   nz_lo;    // Header bytes 23:8 nonzero
		logic                   nz_hi;    // Header bytes 63:16 nonzero
		logic [31:0]            vc_mem;
		logic [15:0]            cfg;
		logic [63:0]            ena;
		logic [63:0]            imask;
		logic [31:0]            area;
		logic [63:0]            in_use;
		logic [63:0]            modif;
		logic [2:0]             lr_ctx;
		logic [31:0]            lr_addr;
		logic [63:0]            lr_cmp;
		logic [31:0]            vcsr;
		logic                   ack;
		logic [31:0]            dat;
	} state_t;

	state_t r;   // Registered state
	state_t n;   // Next state

	logic [31:0] mem [0:511];   // Save area memory
	logic [31:0] comp [0:62];   // Component state file
	logic        mem_we;        // Memory write strobe
	logic [8:0]  mem_wa;        // Memory write word
	logic [31:0] mem_wd;        // Memory write data
	logic [8:0]  mem_ra;        // Sequencer read word
	logic [31:0] mem_rd;        // Sequencer read data
	logic        cs_we;         // Component write strobe
	logic [5:0]  cs_wa;         // Component index written
	logic [31:0] cs_wd;         // Component write data
	logic [8:0]  off;           // Component word offset
	logic [8:0]  aw;            // Area base word
	logic [31:0] rd_val;        // Bus read value
	logic [31:0] wmerge;        // Bus write after byte lanes
	logic        bus_req;       // New bus request
	logic        ld_vc;         // Vector control would load
	logic [11:0] a;             // Word-aligned bus address

	assign aw     = r.area[10:2];
	assign mem_rd = mem[mem_ra];
	assign a      = {WB_ADR_I[11:2], 2'b00};

	// Placement of the current component
	area_offset u_off (
		.comp_idx (r.idx[5:0]),
		.cmp_map  (r.cmp),
		.compact  (r.form),
		.word_off (off)
	);

	// Vector control load condition per form
	always_comb begin
		if (r.form)
			ld_vc = r.requested_component_mask[1] & r.bv[1];
		else
			ld_vc = r.requested_component_mask[1] | r.requested_component_mask[2];
	end

	// Bus read decode; unmapped words read zero
	always_comb begin
		rd_val = '0;
		if (WB_ADR_I[11]) begin
			rd_val = mem[WB_ADR_I[10:2]];
		end else if (WB_ADR_I[11:8] == state_save_pkg::COMP_WIN) begin
			if (WB_ADR_I[7:2] != 6'h3f)
				rd_val = comp[WB_ADR_I[7:2]];
		end else begin
			case (a)
				state_save_pkg::OFF_STATUS:    rd_val = {26'h0, r.form, r.fault, r.done, r.busy};
				state_save_pkg::OFF_CONFIG:    rd_val = {16'h0, r.cfg};
				state_save_pkg::OFF_ENA_LO:    rd_val = r.ena[31:0];
				state_save_pkg::OFF_ENA_HI:    rd_val = r.ena[63:32];
				state_save_pkg::OFF_IMASK_LO:  rd_val = r.imask[31:0];
				state_save_pkg::OFF_IMASK_HI:  rd_val = r.imask[63:32];
				state_save_pkg::OFF_AREA:      rd_val = r.area;
				state_save_pkg::OFF_INUSE_LO:  rd_val = r.in_use[31:0];
				state_save_pkg::OFF_INUSE_HI:  rd_val = r.in_use[63:32];
				state_save_pkg::OFF_MOD_LO:    rd_val = r.modif[31:0];
				state_save_pkg::OFF_MOD_HI:    rd_val = r.modif[63:32];
				state_save_pkg::OFF_LR_CTX:    rd_val = {29'h0, r.lr_ctx};
				state_save_pkg::OFF_LR_ADDR:   rd_val = r.lr_addr;
				state_save_pkg::OFF_LR_CMP_LO: rd_val = r.lr_cmp[31:0];
				state_save_pkg::OFF_LR_CMP_HI: rd_val = r.lr_cmp[63:32];
				state_save_pkg::OFF_VCSR:      rd_val = r.vcsr;
				state_save_pkg::OFF_VCMASK:    rd_val = state_save_pkg::VCMASK_VAL;
				state_save_pkg::OFF_REQUESTED_COMPONENT_MASK_LO:   rd_val = r.requested_component_mask[31:0];
				state_save_pkg::OFF_REQUESTED_COMPONENT_MASK_HI:   rd_val = r.requested_component_mask[63:32];
				default:                       rd_val = '0;
			endcase
		end
	end

	// Byte-lane merge with the current word
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmerge[8*b +: 8] = WB_SEL_I[b] ? WB_DAT_I[8*b +: 8] : rd_val[8*b +: 8];
		end
	end

	assign bus_req = WB_CYC_I && WB_STB_I && !r.ack;

	// Next state: bus slave and sequencer
	always_comb begin
		n      = r;
		n.ack  = 1'b0;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = '0;
		mem_ra = aw + state_save_pkg::W_HDR + {2'b00, r.idx};
		cs_we  = 1'b0;
		cs_wa  = '0;
		cs_wd  = '0;

		// One-cycle answer; writes ignored while busy to keep a run coherent
		if (bus_req) begin
			n.ack = 1'b1;
			n.dat = rd_val;
			if (WB_WE_I && !r.busy) begin
				if (WB_ADR_I[11]) begin
					mem_we = 1'b1;
					mem_wa = WB_ADR_I[10:2];
					mem_wd = wmerge;
				end else if (WB_ADR_I[11:8] == state_save_pkg::COMP_WIN) begin
					if (WB_ADR_I[7:2] != 6'h3f) begin
						cs_we = 1'b1;
						cs_wa = WB_ADR_I[7:2];
						cs_wd = wmerge;
						n.in_use[WB_ADR_I[7:2]] = (wmerge != '0);
						n.modif[WB_ADR_I[7:2]]  = 1'b1;
					end
				end else begin
					case (a)
						state_save_pkg::OFF_CTRL: begin
							if (wmerge[state_save_pkg::CTRL_START]) begin
								n.st    = state_save_pkg::S_CHECK;
								n.op    = wmerge[state_save_pkg::CTRL_OP];
								n.busy  = 1'b1;
								n.done  = 1'b0;
								n.fault = state_save_pkg::FLT_NONE;
								n.form  = 1'b0;
							end
						end
						state_save_pkg::OFF_CONFIG:   n.cfg         = wmerge[15:0];
						state_save_pkg::OFF_ENA_LO:   n.ena[31:0]   = wmerge;
						state_save_pkg::OFF_ENA_HI:   n.ena[63:32]  = wmerge;
						state_save_pkg::OFF_IMASK_LO: n.imask[31:0] = wmerge;
						state_save_pkg::OFF_IMASK_HI: n.imask[63:32] = wmerge;
						state_save_pkg::OFF_AREA:     n.area        = wmerge;
						state_save_pkg::OFF_VCSR:     n.vcsr        = wmerge;
						default: ;
					endcase
				end
			end
		end

		// Instruction sequencer
		case (r.st)
			state_save_pkg::S_IDLE: ;
			state_save_pkg::S_CHECK: begin
				n.requested_component_mask  = r.ena & r.imask;
				n.idx   = '0;
				n.nz_lo = 1'b0;
				n.nz_hi = 1'b0;
				n.st    = state_save_pkg::S_HDR;
				if (!r.cfg[state_save_pkg::CFG_OSE]) begin
					n.fault = state_save_pkg::FLT_UD;
					n.st    = state_save_pkg::S_FIN;
				end else if (r.cfg[state_save_pkg::CFG_TS]) begin
					n.fault = state_save_pkg::FLT_NM;
					n.st    = state_save_pkg::S_FIN;
				end else if ((r.area[5:0] & state_save_pkg::ALIGN_MSK) != 6'h00) begin
					n.st = state_save_pkg::S_FIN;
					if (r.cfg[state_save_pkg::CFG_AM] && r.cfg[state_save_pkg::CFG_AC]
							&& r.cfg[state_save_pkg::CFG_CPL +: 2] == state_save_pkg::CPL_USER)
						n.fault = state_save_pkg::FLT_AC;
					else
						n.fault = state_save_pkg::FLT_GP;
				end
			end
			state_save_pkg::S_HDR: begin
				// Header words 0..15, then the stored vector control word
				if (r.idx == state_save_pkg::HDR_WORDS) begin
					mem_ra   = aw + state_save_pkg::W_VCSR;
					n.vc_mem = mem_rd;
					n.form   = r.op & r.cfg[state_save_pkg::CFG_CMPS] & r.cmp[63];
					n.st     = state_save_pkg::S_VALID;
				end else begin
					case (r.idx)
						7'h00:   n.bv[31:0]   = mem_rd;
						7'h01:   n.bv[63:32]  = mem_rd;
						7'h02:   n.cmp[31:0]  = mem_rd;
						7'h03:   n.cmp[63:32] = mem_rd;
						default: ;
					endcase
					if (r.idx >= 7'h02 && r.idx <= 7'h05 && mem_rd != '0)
						n.nz_lo = 1'b1;
					if (r.idx >= 7'h04 && mem_rd != '0)
						n.nz_hi = 1'b1;
					n.idx = r.idx + 7'h01;
				end
			end
			state_save_pkg::S_VALID: begin
				n.idx = '0;
				n.st  = state_save_pkg::S_COMP;
				// Nothing architectural has changed yet
				if (r.op) begin
					if (!r.form && (((r.bv & ~r.ena) != '0) || r.nz_lo)) begin
						n.fault = state_save_pkg::FLT_GP;
						n.st    = state_save_pkg::S_FIN;
					end else if (r.form && (((r.cmp[62:0] & ~r.ena[62:0]) != '0)
							|| ((r.bv & ~r.cmp) != '0) || r.nz_hi)) begin
						n.fault = state_save_pkg::FLT_GP;
						n.st    = state_save_pkg::S_FIN;
					end else if (ld_vc && ((r.vc_mem & ~state_save_pkg::VCMASK_VAL) != '0)) begin
						n.fault = state_save_pkg::FLT_GP;
						n.st    = state_save_pkg::S_FIN;
					end
				end
			end
			state_save_pkg::S_COMP: begin
				mem_ra = aw + off;
				if (r.requested_component_mask[r.idx[5:0]]) begin
					if (!r.op) begin
						mem_we = 1'b1;
						mem_wa = aw + off;
						mem_wd = comp[r.idx[5:0]];
					end else begin
						cs_we = 1'b1;
						cs_wa = r.idx[5:0];
						cs_wd = r.bv[r.idx[5:0]] ? mem_rd : 32'h0;
					end
				end
				n.idx = r.idx + 7'h01;
				if (r.idx == state_save_pkg::LAST_COMP) begin
					n.idx = '0;
					n.st  = state_save_pkg::S_VC;
				end
			end
			state_save_pkg::S_VC: begin
				n.idx = r.idx + 7'h01;
				if (!r.op) begin
					if (r.requested_component_mask[1] || r.requested_component_mask[2]) begin
						mem_we = 1'b1;
						mem_wa = aw + (r.idx[0] ? state_save_pkg::W_VCMASK : state_save_pkg::W_VCSR);
						mem_wd = r.idx[0] ? state_save_pkg::VCMASK_VAL : r.vcsr;
					end
				end else if (ld_vc) begin
					n.vcsr = r.vc_mem;
				end else if (r.form && r.requested_component_mask[1] && !r.bv[1]) begin
					n.vcsr = state_save_pkg::VCSR_INIT;
				end
				if (r.idx[0])
					n.st = state_save_pkg::S_WRAP;
			end
			state_save_pkg::S_WRAP: begin
				n.idx = r.idx + 7'h01;
				if (!r.op) begin
					// Only the state bitmap words are written back
					mem_we = 1'b1;
					mem_wa = aw + state_save_pkg::W_HDR + {8'h00, r.idx[0]};
					mem_wd = r.idx[0] ? ((r.bv[63:32] & ~r.requested_component_mask[63:32]) | (r.in_use[63:32] & r.requested_component_mask[63:32]))
						: ((r.bv[31:0] & ~r.requested_component_mask[31:0]) | (r.in_use[31:0] & r.requested_component_mask[31:0]));
					if (r.idx[0])
						n.st = state_save_pkg::S_FIN;
				end else begin
					n.in_use  = (r.in_use & ~r.requested_component_mask) | (r.requested_component_mask & r.bv);
					n.modif   = ~r.requested_component_mask;
					n.lr_ctx  = {r.cfg[state_save_pkg::CFG_NR], r.cfg[state_save_pkg::CFG_CPL +: 2]};
					n.lr_addr = r.area;
					n.lr_cmp  = r.form ? r.cmp : 64'h0;
					n.st      = state_save_pkg::S_FIN;
				end
			end
			state_save_pkg::S_FIN: begin
				n.busy = 1'b0;
				n.done = 1'b1;
				n.st   = state_save_pkg::S_IDLE;
			end
			default: n.st = state_save_pkg::S_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			r        <= '0;
			r.st     <= state_save_pkg::S_IDLE;
			r.fault  <= state_save_pkg::FLT_NONE;
			r.cfg    <= state_save_pkg::CFG_RST;
			r.ena    <= state_save_pkg::ENA_RST;
			r.in_use <= state_save_pkg::ALL_ONES >> 1;
			r.modif  <= state_save_pkg::ALL_ONES;
			r.vcsr   <= state_save_pkg::VCSR_INIT;
		end else begin
			r <= n;
		end
	end

	// Memories carry no reset; contents are software's to set up
	always_ff @(posedge CLOCK) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
		if (cs_we)
			comp[cs_wa] <= cs_wd;
	end

	assign WB_DAT_O = r.dat;
	assign WB_ACK_O = r.ack;
	assign BUSY     = r.busy;
endmodule // state_save_restore

// ===== verif/state_save_restore_chk.sv
`timescale 1ns/1ps
module state_save_restore_chk (
	// Clock and reset
	input wire logic        CLOCK,
	input wire logic        RST_N,
	// Bus
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [11:0] WB_ADR_I,
	input wire logic [3:0]  WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	// Status
	input wire logic        BUSY
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	logic        take;    // Request taken at this edge
	logic        rd;      // Read taken at this edge
	logic        start;   // Instruction launch
	logic [31:0] imask_r; // Shadow of the low instruction mask
	assign take  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign rd    = take && !WB_WE_I;
	assign start = take && WB_WE_I && WB_ADR_I == 12'h000 && WB_SEL_I[0] && WB_DAT_I[0] && !BUSY;
	// Writes while busy are dropped, so the shadow skips them too
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) imask_r <= 32'h00000000;
		else if (take && WB_WE_I && !BUSY && WB_ADR_I == 12'h014 && WB_SEL_I == 4'hf) imask_r <= WB_DAT_I;
	end
	ack_timely_a:
	assert property (take |=> WB_ACK_O) else $error("request not acked next cycle");
	ack_single_a:
	assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
	ack_cause_a:
	assert property (WB_ACK_O |-> $past(take)) else $error("ack without request");
	busy_start_a:
	assert property (start |=> BUSY) else $error("busy not raised on start");
	busy_bound_a:
	assert property ($rose(BUSY) |-> ##[1:120] !BUSY) else $error("instruction did not end");
	hole_zero_a:
	assert property (WB_ACK_O && $past(rd && WB_ADR_I == 12'h0f0) |-> WB_DAT_O == 32'h00000000)
		else $error("unmapped read not zero");
	vcmask_ro_a:
	assert property (WB_ACK_O && $past(rd && WB_ADR_I == 12'h044) |-> WB_DAT_O == 32'h0000ffff)
		else $error("vector mask value wrong");
	imask_rb_a:
	assert property (WB_ACK_O && $past(rd && WB_ADR_I == 12'h014) |-> WB_DAT_O == imask_r)
		else $error("instruction mask readback wrong");
	// Main scenarios
	cover property (start && WB_DAT_I[1]);
	cover property (start && !WB_DAT_I[1]);
	cover property ($fell(BUSY));
endmodule // state_save_restore_chk

bind state_save_restore state_save_restore_chk chk_u (.CLOCK(CLOCK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .BUSY(BUSY));

// ===== verif/area_image.sv
`timescale 1ns/1ps
module area_image (
	// Word select and bitmaps
	input  wire logic [3:0]  idx,
	input  wire logic [63:0] st_map,
	input  wire logic [63:0] cmp_map,
	input  wire logic [31:0] junk,
	// Header word
	output logic      [31:0] word
);
	// Software image of the header; reserved words zero unless a test plants junk
	always_comb begin
		case (idx)
			4'h0: word = st_map[31:0];
			4'h1: word = st_map[63:32];
			4'h2: word = cmp_map[31:0];
			4'h3: word = cmp_map[63:32];
			4'h5: word = junk;
			default: word = 32'h00000000;
		endcase
	end
endmodule // area_image

// ===== verif/state_save_restore_tb_top.sv
`timescale 1ns/1ps
module state_save_restore_tb_top;
	logic        clock;          // Core clock
	logic        rst_n = 1'b0;   // Reset, active low
	logic        cyc = 1'b0;     // Bus cycle
	logic        stb = 1'b0;     // Bus strobe
	logic        we = 1'b0;      // Write
	logic [11:0] adr = 12'h000;  // Address
	logic [31:0] wdat = 32'h0;   // Write data
	logic [31:0] rdat;           // Read data
	logic        ack;            // Acknowledge
	logic        busy;           // Instruction running
	logic [3:0]  p_idx = 4'h0;   // Header image controls
	logic [63:0] p_st = 64'h0;
	logic [63:0] p_cmp = 64'h0;
	logic [31:0] p_junk = 32'h0;
	logic [31:0] p_word;
	int          errors = 0;     // Mismatches
	int          checked = 0;    // Comparisons
	int          cycles = 0;     // Hang guard
	logic [31:0] q = 32'h0;      // Last read data
	logic [8:0]  base = 9'h000;  // Area base word
	state_save_restore dut_u (.CLOCK(clock), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .BUSY(busy));
	area_image img_u (.idx(p_idx), .st_map(p_st), .cmp_map(p_cmp), .junk(p_junk), .word(p_word));
	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Hang guard, far above the 1400 or so cycles needed
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 30000) begin
			errors++;
			end_of_test();
		end
	end
	// Verdict
	task automatic end_of_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// One comparison
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Classic cycle held until ack; read data lands in q
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// No local limit: a missing ack is caught by the hang guard
		do begin
			@(posedge clock);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Read and compare
	task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(nm, q, exp);
	endtask
	// Bus address of a save-area word; the area wraps in 512 words
	function automatic logic [11:0] mw(input logic [8:0] w);
		logic [8:0] s;
		s = w + base;
		return {1'b1, s, 2'b00};
	endfunction
	// Configuration, masks and area; upper mask words zero
	task automatic setup(input logic [31:0] cfg, input logic [31:0] ena, input logic [31:0] im, input logic [31:0] ar);
		wb(1'b1, 12'h008, cfg);
		wb(1'b1, 12'h00c, ena);
		wb(1'b1, 12'h010, 32'h0);
		wb(1'b1, 12'h014, im);
		wb(1'b1, 12'h018, 32'h0);
		wb(1'b1, 12'h01c, ar);
		base = ar[10:2];
	endtask
	// Start, then poll until idle; status stays in q
	task automatic run(input logic op);
		wb(1'b1, 12'h000, {30'h0, op, 1'b1});
		do begin
			wb(1'b0, 12'h004, 32'h0);
		end while (q[0] !== 1'b0);
	endtask
	// All sixteen header words from the image
	task automatic hdr(input logic [63:0] st, input logic [63:0] cmp, input logic [31:0] junk);
		p_st = st;
		p_cmp = cmp;
		p_junk = junk;
		for (int i = 0; i < 16; i++) begin
			p_idx = i[3:0];
			#1;
			wb(1'b1, mw(9'h080 + i[8:0]), p_word);
		end
	endtask
	// Restore that must fault and leave vector control alone
	task automatic bad(input logic [63:0] st, input logic [63:0] cmp, input logic [31:0] junk, input logic [31:0] vc);
		hdr(st, cmp, junk);
		wb(1'b1, mw(9'h006), vc);
		wb(1'b1, 12'h040, 32'h55);
		run(1'b1);
		check("bad_fault", {29'h0, q[4:2]}, 32'h3);
		rc("bad_vcsr", 12'h040, 32'h55);
	endtask
	// Reset values and a hole in the map
	task automatic t_reset;
		rc("ena", 12'h00c, 32'h3);
		rc("inuse_hi", 12'h024, 32'h7fffffff);
		rc("mod_hi", 12'h02c, 32'hffffffff);
		rc("vcsr", 12'h040, 32'h1f80);
		rc("vcmask", 12'h044, 32'h0000ffff);
		rc("hole", 12'h0f0, 32'h0);
	endtask
	// Entry faults in priority order, nothing updated
	task automatic t_fault;
		logic [31:0] cfg [4] = '{32'h0, 32'h9, 32'h1, 32'h721};
		logic [31:0] ar [4] = '{32'h0, 32'h0, 32'h20, 32'h20};
		for (int i = 0; i < 4; i++) begin
			setup(cfg[i], 32'h3, 32'h3, ar[i]);
			run(i[0]);
			check("entry_fault", {29'h0, q[4:2]}, i + 1);
		end
		rc("mod_lo", 12'h028, 32'hffffffff);
	endtask
	// Save merges the state bitmap, skips compaction, stores vector control for bit 2
	task automatic t_save;
		setup(32'h1, 32'h7, 32'h5, 32'h0);
		rc("imask", 12'h014, 32'h5);
		wb(1'b1, 12'h100, 32'ha5);
		wb(1'b1, 12'h108, 32'h5a);
		hdr(64'h8000000000000022, 64'h1234, 32'h0);
		wb(1'b1, mw(9'h090), 32'hdead);
		wb(1'b1, mw(9'h006), 32'h0);
		wb(1'b1, mw(9'h007), 32'h0);
		run(1'b0);
		check("save_status", {28'h0, q[4:1]}, 32'h1);
		// Requested mask is only formed once the instruction runs
		rc("requested_component_mask", 12'h048, 32'h5);
		rc("st_lo", mw(9'h080), 32'h27);
		rc("st_hi", mw(9'h081), 32'h80000000);
		rc("cmp_lo", mw(9'h082), 32'h1234);
		rc("comp0", mw(9'h000), 32'ha5);
		rc("comp2", mw(9'h090), 32'h5a);
		rc("vc", mw(9'h006), 32'h1f80);
		rc("vcm", mw(9'h007), 32'h0000ffff);
	endtask
	// Standard restore, tracking, record and its header faults
	task automatic t_std;
		setup(32'h1c01, 32'h7, 32'h7, 32'h40);
		hdr(64'h5, 64'h0, 32'h0);
		wb(1'b1, mw(9'h000), 32'h11);
		wb(1'b1, mw(9'h001), 32'h99);
		wb(1'b1, mw(9'h090), 32'h22);
		wb(1'b1, mw(9'h006), 32'h123);
		run(1'b1);
		check("std_status", {27'h0, q[5:1]}, 32'h1);
		rc("c0", 12'h100, 32'h11);
		rc("c1", 12'h104, 32'h0);
		rc("c2", 12'h108, 32'h22);
		rc("vcsr", 12'h040, 32'h123);
		wb(1'b0, 12'h020, 32'h0);
		check("inuse", q & 32'h5, 32'h5);
		wb(1'b0, 12'h028, 32'h0);
		check("mod", q | 32'h7, 32'hffffffff);
		rc("lr_ctx", 12'h030, 32'h6);
		rc("lr_addr", 12'h034, 32'h40);
		rc("lr_cmp", 12'h03c, 32'h0);
		bad(64'hd, 64'h0, 32'h0, 32'h123);
		bad(64'h5, 64'h1, 32'h0, 32'h123);
		bad(64'h5, 64'h0, 32'h1, 32'h123);
		bad(64'h5, 64'h0, 32'h0, 32'h10000);
	endtask
	// Compacted restore, its faults, and the unsupported case
	task automatic t_cmp;
		setup(32'h1001, 32'hf, 32'hf, 32'h0);
		hdr(64'h9, 64'h8000000000000009, 32'h0);
		wb(1'b1, 12'h104, 32'h88);
		wb(1'b1, 12'h108, 32'h77);
		wb(1'b1, 12'h040, 32'h55);
		wb(1'b1, mw(9'h000), 32'h66);
		wb(1'b1, mw(9'h090), 32'h33);
		wb(1'b1, mw(9'h091), 32'h44);
		wb(1'b1, mw(9'h006), 32'h123);
		run(1'b1);
		check("cmp_status", {27'h0, q[5:1]}, 32'h11);
		rc("c0", 12'h100, 32'h66);
		rc("c1", 12'h104, 32'h0);
		rc("c2", 12'h108, 32'h0);
		rc("c3", 12'h10c, 32'h33);
		rc("vcsr", 12'h040, 32'h1f80);
		rc("lr_lo", 12'h038, 32'h9);
		rc("lr_hi", 12'h03c, 32'h80000000);
		bad(64'hd, 64'h8000000000000009, 32'h0, 32'h0);
		bad(64'h9, 64'h8000000000000019, 32'h0, 32'h0);
		bad(64'h9, 64'h8000000000000009, 32'h1, 32'h0);
		setup(32'h1, 32'h7, 32'h7, 32'h0);
		hdr(64'h5, 64'h8000000000000000, 32'h0);
		run(1'b1);
		check("nocs", {28'h0, q[5:2]}, 32'h3);
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_fault();
		t_save();
		t_std();
		t_cmp();
		end_of_test();
	end
endmodule // state_save_restore_tb_top
